// [verilog/gateway_status_pkg.sv]
// constants and types of the gateway status indicator
package gateway_status_pkg;
  localparam int clk_hz = 20_000_000;
  localparam int tick_ms = 1;
  localparam int tick_cycles = clk_hz / 1000 * tick_ms;
  localparam int half_period_ms = 250;
  localparam int idle_limit_ms = 500;
  localparam int warning_hold_ms = 60_000;
  localparam int tick_count_w = 15;
  localparam int ms_count_w = 16;
  localparam logic [3:0] serious_max = 4'h5;
  localparam logic [3:0] no_error = 4'h0;
  localparam logic [1:0] lamp_off = 2'h0;
  localparam logic [1:0] lamp_green = 2'h1;
  localparam logic [1:0] lamp_red = 2'h2;
  localparam logic [7:0] config_id = 8'hff;
  localparam logic [1:0] irq_serious_bit = 2'h0;
  localparam logic [1:0] irq_warning_bit = 2'h1;
  localparam logic [1:0] irq_idle_bit = 2'h2;
  localparam logic [7:0] addr_status = 8'h00;
  localparam logic [7:0] addr_mask = 8'h04;
  localparam logic [7:0] addr_error = 8'h08;
  localparam logic [7:0] addr_switches = 8'h0c;
  typedef enum logic [2:0] {
    serial_idle_type = 3'b000,
    serial_active_type = 3'b001,
    serial_sporadic_type = 3'b011,
    serial_error_type = 3'b010,
    serial_config_type = 3'b110
  } serial_state_type;
endpackage : gateway_status_pkg

// [verilog/gateway_tick_divider.sv]
// divider producing one-cycle enable pulses
`timescale 1ns/10ps
`default_nettype none
module gateway_tick_divider #(
  parameter int divide = 20000,
  parameter int width = 15
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic enable,
  output logic pulse
);
  logic [width-1:0] count;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      count <= '0;
      pulse <= 1'b0;
    end else begin
      pulse <= 1'b0;
      if (enable) begin
        if (count == width'(divide - 1)) begin
          count <= '0;
          pulse <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end
endmodule : gateway_tick_divider
`default_nettype wire

// [verilog/gateway_status_indicator.sv]
// status lamps, code display and switch sampling of the gateway
// Operation
// (R1) reset-released lamp green unless fieldbus reset
// (R2) red lamp while outgoing segment off
// (R3) bus-active lamp green while layer 2 active
// (R4) bus state: green, alternating after 0.5s, red
// (R5) serial lamp patterns by serial state
// (R6) error flashes code, else station address
// (R7) lamps meaningless in configuration mode
// (R8) station id sampled once at activation
// (R9) rate switch selects 500 kB or 2 MB
// (R10) interface switch selects differential or single-ended
// (R11) errors 1-5 held, 6-15 cleared after minute
// (R12) patterns toggle every 250 ms from 1 ms tick
`timescale 1ns/10ps
`default_nettype none
module gateway_status_indicator
  import gateway_status_pkg::*;
#(
  parameter int tick_len = tick_cycles,
  parameter int warning_ms = warning_hold_ms,
  parameter int idle_ms = idle_limit_ms,
  parameter int half_ms = half_period_ms
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic fieldbus_reset,
  input wire logic segment_off,
  input wire logic layer2_active,
  input wire logic fieldbus_exchange,
  input wire logic serial_exchange,
  input wire logic serial_link_ok,
  input wire logic config_mode,
  input wire logic activate,
  input wire logic error_valid,
  input wire logic [3:0] error_number,
  input wire logic [7:0] active_station,
  input wire logic [3:0] station_id_high_switch,
  input wire logic [3:0] station_id_low_switch,
  input wire logic rate_switch,
  input wire logic interface_switch,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic reset_released_lamp,
  output logic remote_segment_off_lamp,
  output logic bus_active_lamp,
  output logic [1:0] bus_state_lamp,
  output logic [1:0] serial_state_lamp,
  output logic [3:0] code_display_lamps,
  output logic [7:0] station_id,
  output logic rate_2mb,
  output logic interface_single_ended
);
  logic ms_tick;
  logic phase;
  logic [ms_count_w-1:0] half_count;
  logic [ms_count_w-1:0] idle_count;
  logic [ms_count_w-1:0] warn_count;
  logic fieldbus_idle;
  logic serial_ever;
  logic [ms_count_w-1:0] serial_gap;
  logic [3:0] held_error;
  logic id_taken;
  serial_state_type serial_state;
  serial_state_type next_serial_state;
  logic [2:0] status;
  logic [2:0] mask;
  logic [2:0] events;
  logic idle_seen;

  ////////////////////////////////////////////////////////////////////
  // 1 ms tick and blink phase
  gateway_tick_divider #(
    .divide(tick_len),
    .width(tick_count_w)
  ) tick_div (
    .mclk(mclk),
    .reset(reset),
    .enable(1'b1),
    .pulse(ms_tick)
  );

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      half_count <= '0;
      phase <= 1'b0;
    end else if (ms_tick) begin
      if (half_count == ms_count_w'(half_ms - 1)) begin // see (R12)
        half_count <= '0;
        phase <= ~phase;
      end else begin
        half_count <= half_count + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // fieldbus activity watch
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      idle_count <= '0;
      fieldbus_idle <= 1'b0;
    end else if (fieldbus_exchange) begin
      idle_count <= '0;
      fieldbus_idle <= 1'b0;
    end else if (ms_tick && !fieldbus_idle) begin
      if (idle_count == ms_count_w'(idle_ms - 1)) begin // see (R4)
        fieldbus_idle <= 1'b1;
      end else begin
        idle_count <= idle_count + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // fieldbus lamps
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      reset_released_lamp <= 1'b0;
      remote_segment_off_lamp <= 1'b0;
      bus_active_lamp <= 1'b0;
      bus_state_lamp <= lamp_off;
    end else begin
      reset_released_lamp <= ~fieldbus_reset; // see (R1)
      remote_segment_off_lamp <= segment_off; // see (R2)
      bus_active_lamp <= layer2_active; // see (R3)
      if (fieldbus_reset) begin // see (R4)
        bus_state_lamp <= lamp_red;
      end else if (fieldbus_idle) begin
        bus_state_lamp <= phase ? lamp_red : lamp_green;
      end else begin
        bus_state_lamp <= lamp_green;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // error hold: serious until power cycle, warnings one minute
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      held_error <= no_error;
      warn_count <= '0;
    end else if (held_error != no_error && held_error <= serious_max) begin
      held_error <= held_error; // see (R11)
    end else if (error_valid && error_number != no_error) begin
      held_error <= error_number;
      warn_count <= '0;
    end else if (held_error != no_error && ms_tick) begin
      if (warn_count == ms_count_w'(warning_ms - 1)) begin // see (R11)
        held_error <= no_error;
        warn_count <= '0;
      end else begin
        warn_count <= warn_count + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // serial-side state
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      serial_ever <= 1'b0;
      serial_gap <= '0;
    end else if (serial_exchange) begin
      serial_ever <= 1'b1;
      serial_gap <= '0;
    end else if (ms_tick && serial_gap != ms_count_w'(idle_ms)) begin
      serial_gap <= serial_gap + 1'b1;
    end
  end

  always_comb begin
    case (1'b1)
      config_mode: next_serial_state = serial_config_type;
      (held_error != no_error): next_serial_state = serial_error_type;
      (!serial_ever): next_serial_state = serial_idle_type;
      (serial_link_ok && serial_gap == ms_count_w'(idle_ms)):
        next_serial_state = serial_sporadic_type;
      default: next_serial_state = serial_active_type;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      serial_state <= serial_idle_type;
    end else begin
      serial_state <= next_serial_state;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      serial_state_lamp <= lamp_off;
      code_display_lamps <= 4'h0;
    end else begin
      case (serial_state) // see (R5)
        serial_active_type: serial_state_lamp <= lamp_green;
        serial_sporadic_type: serial_state_lamp <= phase ? lamp_green : lamp_off;
        serial_idle_type: serial_state_lamp <= phase ? lamp_red : lamp_green;
        serial_error_type: serial_state_lamp <= lamp_red;
        serial_config_type: serial_state_lamp <= phase ? lamp_red : lamp_off; // see (R7)
        default: serial_state_lamp <= lamp_off;
      endcase
      if (serial_state == serial_error_type) begin // see (R6)
        code_display_lamps <= phase ? held_error : 4'h0;
      end else begin
        code_display_lamps <= active_station[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // switch sampling
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      station_id <= 8'h00;
      id_taken <= 1'b0;
    end else if (activate && !id_taken) begin // see (R8)
      station_id <= {station_id_high_switch, station_id_low_switch};
      id_taken <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rate_2mb <= 1'b0;
      interface_single_ended <= 1'b0;
    end else begin
      rate_2mb <= rate_switch; // see (R9)
      interface_single_ended <= interface_switch; // see (R10)
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt status, mask and register port
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      idle_seen <= 1'b0;
    end else begin
      idle_seen <= fieldbus_idle;
    end
  end

  always_comb begin
    events = 3'h0;
    events[irq_serious_bit] = error_valid && error_number != no_error
                              && error_number <= serious_max;
    events[irq_warning_bit] = error_valid && error_number > serious_max;
    events[irq_idle_bit] = fieldbus_idle && !idle_seen;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      status <= 3'h0;
    end else if (reg_write && reg_addr == addr_status) begin
      status <= (status & ~reg_wdata[2:0]) | events;
    end else begin
      status <= status | events;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mask <= 3'h0;
    end else if (reg_write && reg_addr == addr_mask) begin
      mask <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0;
    end else if (reg_read) begin
      case (reg_addr)
        addr_status: reg_rdata <= {29'h0, status};
        addr_mask: reg_rdata <= {29'h0, mask};
        addr_error: reg_rdata <= {25'h0, serial_state, held_error};
        addr_switches: reg_rdata <= {22'h0, interface_single_ended, rate_2mb, station_id};
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  chk_reset_lamp: assert property (@(posedge mclk) disable iff (reset) // see (R1)
    fieldbus_reset |=> !reset_released_lamp && bus_state_lamp == lamp_red)
    else $error("reset lamp wrong during fieldbus reset");
  chk_segment_lamp: assert property (@(posedge mclk) disable iff (reset) // see (R2)
    segment_off |=> remote_segment_off_lamp)
    else $error("segment off lamp not lit");
  chk_active_lamp: assert property (@(posedge mclk) disable iff (reset) // see (R3)
    layer2_active |=> bus_active_lamp)
    else $error("bus active lamp not lit");
  chk_bus_green: assert property (@(posedge mclk) disable iff (reset) // see (R4)
    fieldbus_exchange ##1 !fieldbus_reset |=> bus_state_lamp == lamp_green)
    else $error("bus state lamp not green after exchange");
  chk_bus_blink: assert property (@(posedge mclk) disable iff (reset) // see (R4)
    fieldbus_idle && !fieldbus_reset |=> bus_state_lamp != lamp_off)
    else $error("bus state lamp dark while idle");
  chk_serial_green: assert property (@(posedge mclk) disable iff (reset) // see (R5)
    serial_state == serial_active_type |=> serial_state_lamp == lamp_green)
    else $error("serial lamp not green while exchanging");
  chk_serial_alternate: assert property (@(posedge mclk) disable iff (reset) // see (R5)
    !reset && serial_state == serial_idle_type
    |=> serial_state_lamp == lamp_red || serial_state_lamp == lamp_green)
    else $error("serial lamp not alternating before first exchange");
  chk_serial_flash: assert property (@(posedge mclk) disable iff (reset) // see (R5)
    serial_state == serial_sporadic_type |=> serial_state_lamp != lamp_red)
    else $error("serial lamp red while link fine");
  chk_serial_error: assert property (@(posedge mclk) disable iff (reset) // see (R5)
    serial_state == serial_error_type |=> serial_state_lamp == lamp_red)
    else $error("serial lamp not red on error");
  chk_display_addr: assert property (@(posedge mclk) disable iff (reset) // see (R6)
    serial_state == serial_active_type |=> code_display_lamps == $past(active_station[3:0]))
    else $error("display not showing station");
  chk_id_held: assert property (@(posedge mclk) disable iff (reset) // see (R8)
    id_taken |=> $stable(station_id))
    else $error("station id changed after activation");
  chk_serious_hold: assert property (@(posedge mclk) disable iff (reset) // see (R11)
    held_error != no_error && held_error <= serious_max |=> $stable(held_error))
    else $error("serious error released");
  chk_rate_follow: assert property (@(posedge mclk) disable iff (reset) // see (R9)
    rate_switch |=> rate_2mb)
    else $error("rate selection not followed");
  chk_iface_follow: assert property (@(posedge mclk) disable iff (reset) // see (R10)
    interface_switch |=> interface_single_ended)
    else $error("interface selection not followed");
  chk_error_display: assert property (@(posedge mclk) disable iff (reset) // see (R6)
    serial_state == serial_error_type
    |=> code_display_lamps == 4'h0 || code_display_lamps == $past(held_error))
    else $error("display not flashing error number");
  chk_error_capture: assert property (@(posedge mclk) disable iff (reset) // see (R11)
    error_valid && error_number != no_error
    && (held_error == no_error || held_error > serious_max)
    |=> held_error == $past(error_number))
    else $error("reported error not taken");
endmodule : gateway_status_indicator
`default_nettype wire

// [testbench/operator_model.sv]
// operator model that sets the selector switches
`timescale 1ns/10ps
`default_nettype none
module operator_model (
  input wire logic mclk,
  input wire logic [7:0] want_id,
  input wire logic want_rate,
  input wire logic want_iface,
  output logic [3:0] high_sw,
  output logic [3:0] low_sw,
  output logic rate_sw,
  output logic iface_sw
);
  initial begin
    high_sw = 4'h0;
    low_sw = 4'h0;
    rate_sw = 1'b0;
    iface_sw = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // switches move only just after a clock edge
  always @(posedge mclk) begin
    high_sw <= want_id[7:4];
    low_sw <= want_id[3:0];
    rate_sw <= want_rate;
    iface_sw <= want_iface;
  end
endmodule : operator_model
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench of the gateway status indicator
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import gateway_status_pkg::*;
  localparam int tl = 20;
  localparam int wl = 5;
  localparam int il = 4;
  localparam int hl = 2;
  logic mclk, reset, fieldbus_reset, segment_off, layer2_active, fieldbus_exchange;
  logic activate, error_valid, reg_write, reg_read, irq, rr_lamp, seg_lamp, ba_lamp;
  logic rate_2mb, iface_se, rate_sw, iface_sw, want_rate, want_iface, fb_run, rd_seen;
  logic seen_a, seen_b, seen_c;
  logic serial_exchange, serial_link_ok, config_mode;
  logic [3:0] error_number, high_sw, low_sw, code_lamps;
  logic [7:0] active_station, reg_addr, station_id, want_id, id0;
  logic [31:0] reg_wdata, reg_rdata;
  logic [1:0] bus_lamp, ser_lamp;
  logic [31:0] exp_q[$];
  int seed = 75913;
  int err_total = 0;
  int n_compared = 0;
  gateway_status_indicator #(.tick_len(tl), .warning_ms(wl), .idle_ms(il), .half_ms(hl)) i_dut (
    .mclk(mclk), .reset(reset), .fieldbus_reset(fieldbus_reset), .segment_off(segment_off),
    .layer2_active(layer2_active), .fieldbus_exchange(fieldbus_exchange),
    .serial_exchange(serial_exchange), .serial_link_ok(serial_link_ok),
    .config_mode(config_mode), .activate(activate),
    .error_valid(error_valid), .error_number(error_number), .active_station(active_station),
    .station_id_high_switch(high_sw), .station_id_low_switch(low_sw), .rate_switch(rate_sw),
    .interface_switch(iface_sw), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
    .reset_released_lamp(rr_lamp), .remote_segment_off_lamp(seg_lamp),
    .bus_active_lamp(ba_lamp), .bus_state_lamp(bus_lamp), .serial_state_lamp(ser_lamp),
    .code_display_lamps(code_lamps), .station_id(station_id), .rate_2mb(rate_2mb),
    .interface_single_ended(iface_se));
  operator_model i_operator (.mclk(mclk), .want_id(want_id), .want_rate(want_rate),
    .want_iface(want_iface), .high_sw(high_sw), .low_sw(low_sw), .rate_sw(rate_sw),
    .iface_sw(iface_sw));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) fieldbus_exchange <= fb_run;
  always @(posedge mclk) rd_seen <= reg_read;
  always @(negedge mclk) begin
    if (rd_seen === 1'b1) check("reg_rdata", exp_q.pop_front(), reg_rdata);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] got);
    n_compared++;
    if (got !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, e, got);
    end
  endtask : check
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    reg_read <= 1'b0;
  endtask : reg_rd
  task automatic look(input int n);
    repeat (n) @(posedge mclk);
    #5;
  endtask : look
  task automatic raise(input logic [3:0] code);
    @(posedge mclk);
    error_valid <= 1'b1;
    error_number <= code;
    @(posedge mclk);
    error_valid <= 1'b0;
  endtask : raise
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8000) @(posedge mclk);
    err_total++;
    close_out();
  end
  initial begin
    {reset, fb_run} = 2'b11;
    {fieldbus_reset, segment_off, layer2_active, activate, error_valid} = 5'h0;
    {reg_write, reg_read, want_rate, want_iface} = 4'h0;
    {error_number, reg_addr, reg_wdata} = 44'h0;
    {serial_exchange, serial_link_ok, config_mode} = 3'b010;
    want_id = 8'($random(seed));
    active_station = 8'($random(seed));
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    look(3);
    check("reset_released_lamp", 32'h1, 32'(rr_lamp));
    {seen_a, seen_b} = 2'b00;
    for (int i = 0; i < 4 * hl * tl; i++) begin
      look(1);
      seen_a |= (ser_lamp === lamp_green);
      seen_b |= (ser_lamp === lamp_red);
    end
    check("serial_state_lamp", 32'h3, 32'({seen_b, seen_a}));
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      segment_off <= i[0];
      layer2_active <= i[1];
      look(2);
      check("remote_segment_off_lamp", 32'(i[0]), 32'(seg_lamp));
      check("bus_active_lamp", 32'(i[1]), 32'(ba_lamp));
    end
    check("code_display_lamps", 32'(active_station[3:0]), 32'(code_lamps));
    id0 = want_id;
    @(posedge mclk);
    activate <= 1'b1;
    want_id <= ~want_id;
    @(posedge mclk);
    activate <= 1'b0;
    look(3);
    check("station_id", 32'(id0), 32'(station_id));
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      want_rate <= i[0];
      want_iface <= i[1];
      look(4);
      check("rate_2mb", 32'(i[0]), 32'(rate_2mb));
      check("interface_single_ended", 32'(i[1]), 32'(iface_se));
      reg_rd(addr_switches, {22'h0, i[1], i[0], id0});
    end
    reg_rd(8'h10, 32'h0);
    $display("test lamps and switches done");
    @(posedge mclk);
    serial_exchange <= 1'b1;
    active_station <= 8'($random(seed));
    look(4);
    check("serial_state_lamp", 32'(lamp_green), 32'(ser_lamp));
    check("code_display_lamps", 32'(active_station[3:0]), 32'(code_lamps));
    @(posedge mclk);
    serial_exchange <= 1'b0;
    look(il * tl + 40);
    {seen_a, seen_b, seen_c} = 3'b000;
    for (int i = 0; i < 4 * hl * tl; i++) begin
      look(1);
      seen_a |= (ser_lamp === lamp_green);
      seen_b |= (ser_lamp === lamp_off);
      seen_c |= (ser_lamp === lamp_red);
    end
    check("serial_state_lamp", 32'h3, 32'({seen_c, seen_b, seen_a}));
    @(posedge mclk);
    config_mode <= 1'b1;
    look(3);
    reg_rd(addr_error, 32'h60);
    @(posedge mclk);
    config_mode <= 1'b0;
    serial_link_ok <= 1'b0;
    look(4);
    check("serial_state_lamp", 32'(lamp_green), 32'(ser_lamp));
    @(posedge mclk);
    serial_link_ok <= 1'b1;
    $display("test serial state done");
    reg_wr(addr_mask, 32'h3);
    raise(4'h9);
    look(3);
    check("irq", 32'h1, 32'(irq));
    reg_rd(addr_error, 32'h29);
    reg_rd(addr_status, 32'h2);
    look(wl * tl + 40);
    reg_rd(addr_error, 32'h30);
    reg_wr(addr_status, 32'h7);
    look(3);
    check("irq", 32'h0, 32'(irq));
    raise(4'h3);
    look(3);
    check("serial_state_lamp", 32'(lamp_red), 32'(ser_lamp));
    check("irq", 32'h1, 32'(irq));
    {seen_a, seen_b} = 2'b00;
    for (int i = 0; i < 4 * hl * tl; i++) begin
      look(1);
      seen_a |= (code_lamps === 4'h3);
      seen_b |= (code_lamps !== 4'h3 && code_lamps !== 4'h0);
    end
    check("code_display_lamps", 32'h1, 32'({seen_b, seen_a}));
    look(wl * tl + 40);
    reg_rd(addr_error, 32'h23);
    reg_wr(addr_mask, 32'h0);
    look(3);
    check("irq", 32'h0, 32'(irq));
    $display("test errors done");
    reg_wr(addr_status, 32'h7);
    @(posedge mclk);
    fb_run <= 1'b0;
    look(il * tl + 20);
    {seen_a, seen_b} = 2'b00;
    for (int i = 0; i < 4 * hl * tl; i++) begin
      look(1);
      seen_a |= (bus_lamp === lamp_green);
      seen_b |= (bus_lamp === lamp_red);
    end
    check("bus_state_lamp", 32'h3, 32'({seen_b, seen_a}));
    reg_rd(addr_status, 32'h4);
    @(posedge mclk);
    fb_run <= 1'b1;
    look(4);
    check("bus_state_lamp", 32'(lamp_green), 32'(bus_lamp));
    @(posedge mclk);
    fieldbus_reset <= 1'b1;
    look(3);
    check("reset_released_lamp", 32'h0, 32'(rr_lamp));
    check("bus_state_lamp", 32'(lamp_red), 32'(bus_lamp));
    @(posedge mclk);
    fieldbus_reset <= 1'b0;
    look(3);
    check("reset_released_lamp", 32'h1, 32'(rr_lamp));
    $display("test fieldbus state done");
    close_out();
  end
endmodule : testbench
`default_nettype wire
